// file: hw/jesd_link_params.svh
// Constants shared by the link transmitter, receiver and package.
// Definitions only; included by bare name.
`ifndef JESD_LINK_PARAMS_SVH
`define JESD_LINK_PARAMS_SVH
// Control character octets
`define OCT_K28_0 8'h1C
`define OCT_K28_3 8'h7C
`define OCT_K28_4 8'h9C
`define OCT_K28_5 8'hBC
`define OCT_K28_7 8'hFC
`define K28_LOW 5'h1C
`define IDLE_OCTET 8'h00
`define SCR_SEED 15'h7FFF
// Sequence counts
`define CGS_K_LAST 3'h3
`define ILAS_LAST_MF 2'h3
`define ILAS_CFG_MF 2'h1
`define ILAS_Q_POS 8'h01
`define ILAS_CFG_FIRST 8'h02
`define ILAS_CFG_LAST 8'h05
// Receiver register map
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_DATA 4'h8
`define CTRL_RESET 32'h000000F0
`define CTRL_ENABLE_BIT 0
`define CTRL_SCR_BIT 1
`define CTRL_MODE_LSB 2
`define CTRL_KM1_LSB 4
`define STAT_ALIGN_BIT 2
`define STAT_CFG_BIT 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: hw/jesd_link_pkg.sv
// Types and coding functions shared by both link ends.
// Assumes the constants header is on the include path.
`include "jesd_link_params.svh"
package jesd_link_pkg;
  typedef enum logic [1:0] {
    TX_CGS = 2'b00,
    TX_WAIT = 2'b01,
    TX_ILAS = 2'b10,
    TX_DATA = 2'b11
  } tx_state_t;
  typedef enum logic [1:0] {
    RX_CGS = 2'b00,
    RX_WAIT = 2'b01,
    RX_ILAS = 2'b10,
    RX_DATA = 2'b11
  } rx_state_t;
  typedef struct packed {
    logic isK;
    logic [7:0] octet;
  } symbol_t;

  function automatic logic [7:0] octetsPerFrame(input logic [1:0] mode);
    return 8'h01 << mode;
  endfunction

  // Configuration octets of the second alignment multiframe
  function automatic logic [7:0] cfgOctet(input logic [7:0] pos,
    input logic [1:0] mode, input logic [4:0] km1, input logic scramble_enable);
    case (pos)
      8'h02: return octetsPerFrame(mode) - 8'h01;
      8'h03: return {3'h0, km1};
      8'h04: return {7'h0, scramble_enable};
      default: return {6'h0, mode};
    endcase
  endfunction

  // Self-synchronous 1 + x^14 + x^15, MSB first; returns {state, octet}
  function automatic logic [22:0] scrambleStep(input logic [7:0] d,
    input logic [14:0] s, input logic descr);
    logic [7:0] o;
    logic [14:0] st;
    o = 8'h00;
    st = s;
    for (int i = 7; i >= 0; i--)
    begin
      o[i] = d[i] ^ st[14] ^ st[13];
      st = {st[13:0], descr ? d[i] : o[i]};
    end
    return {st, o};
  endfunction

  // 8b/10b with running disparity; returns {rdOut, abcdei, fghj}
  function automatic logic [10:0] encode8b10b(input symbol_t s,
    input logic rd);
    logic [5:0] six;
    logic [3:0] four;
    logic rdMid;
    logic [4:0] x;
    logic [2:0] y;
    x = s.octet[4:0];
    y = s.octet[7:5];
    if (s.isK)
      six = 6'b001111;
    else
      case (x)
        5'd0: six = 6'b100111; 5'd1: six = 6'b011101;
        5'd2: six = 6'b101101; 5'd3: six = 6'b110001;
        5'd4: six = 6'b110101; 5'd5: six = 6'b101001;
        5'd6: six = 6'b011001; 5'd7: six = 6'b111000;
        5'd8: six = 6'b111001; 5'd9: six = 6'b100101;
        5'd10: six = 6'b010101; 5'd11: six = 6'b110100;
        5'd12: six = 6'b001101; 5'd13: six = 6'b101100;
        5'd14: six = 6'b011100; 5'd15: six = 6'b010111;
        5'd16: six = 6'b011011; 5'd17: six = 6'b100011;
        5'd18: six = 6'b010011; 5'd19: six = 6'b110010;
        5'd20: six = 6'b001011; 5'd21: six = 6'b101010;
        5'd22: six = 6'b011010; 5'd23: six = 6'b111010;
        5'd24: six = 6'b110011; 5'd25: six = 6'b100110;
        5'd26: six = 6'b010110; 5'd27: six = 6'b110110;
        5'd28: six = 6'b001110; 5'd29: six = 6'b101110;
        5'd30: six = 6'b011110; default: six = 6'b101011;
      endcase
    if (rd && (($countones(six) != 3) || (!s.isK && x == 5'd7)))
      six = ~six;
    rdMid = rd ^ ($countones(six) != 3);
    if (s.isK)
    begin
      case (y)
        3'd0: four = 4'b1011; 3'd1: four = 4'b0110;
        3'd2: four = 4'b1010; 3'd3: four = 4'b1100;
        3'd4: four = 4'b1101; 3'd5: four = 4'b0101;
        3'd6: four = 4'b1001; default: four = 4'b0111;
      endcase
      if (rdMid)
        four = ~four;
    end
    else
    begin
      case (y)
        3'd0: four = 4'b1011; 3'd1: four = 4'b1001;
        3'd2: four = 4'b0101; 3'd3: four = 4'b1100;
        3'd4: four = 4'b1101; 3'd5: four = 4'b1010;
        3'd6: four = 4'b0110;
        default: four = ((!rdMid && (x == 5'd17 || x == 5'd18 ||
          x == 5'd20)) || (rdMid && (x == 5'd11 || x == 5'd13 ||
          x == 5'd14))) ? 4'b0111 : 4'b1110;
      endcase
      if (rdMid && (($countones(four) != 2) || y == 3'd3))
        four = ~four;
    end
    return {rdMid ^ ($countones(four) != 2), six, four};
  endfunction
endpackage

// file: hw/jesd_link_if.sv
// Serial link between the transmitter and the receiver, one lane.
// Characters are carried as parallel 10-bit words, one per clock.
`timescale 1ns/1ns
interface jesd_link_if;
  logic [9:0] txChar;
  logic syncN;
  logic [3:0] txEmph;
  logic txPowered;
  modport tx (output txChar, output txEmph, output txPowered,
    input syncN);
  modport rx (input txChar, input txEmph, input txPowered,
    output syncN);
endinterface

// file: hw/jesd_char_encoder.sv
// Registered 8b/10b encoder holding the running disparity.
// Assumes one symbol per enabled clock from the link transmitter.
`timescale 1ns/1ns
`include "jesd_link_params.svh"
module jesd_char_encoder (
  // Clock and control
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Symbol in, character out
  input jesd_link_pkg::symbol_t symIn,
  output logic [9:0] charOut
);
  import jesd_link_pkg::*;
  logic rd_reg;
  logic [10:0] enc;

  assign enc = encode8b10b(symIn, rd_reg);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rd_reg <= 1'b0;
      charOut <= 10'h000;
    end
    else if (ce)
    begin
      rd_reg <= enc[10];
      charOut <= enc[9:0];
    end
  end
endmodule // jesd_char_encoder

// file: hw/jesd_link_rx.sv
// Link receiver end: comma alignment, lane alignment, descrambling.
// Assumes an AXI4-Lite master for control and a synchronous SYSREF.
`timescale 1ns/1ns
`include "jesd_link_params.svh"
module jesd_link_rx (
  // Clock and control
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic sysref,
  // AXI4-Lite slave
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Received samples
  output logic [7:0] rxData,
  output logic rxValid,
  // Link
  jesd_link_if.rx link
);
  import jesd_link_pkg::*;
  localparam logic [31:0] CtrlReset = `CTRL_RESET;

  function automatic logic addrKnown(input logic [3:0] a);
    return a == `REG_CTRL || a == `REG_STATUS || a == `REG_DATA;
  endfunction

  logic [7:0] ctrlByte_reg [4];
  logic [31:0] ctrl;
  logic rxRst, scrEn, wrFire, alignErr_reg, cfgErr_reg, sysrefD_reg;
  logic [1:0] mode, mf_reg;
  logic [4:0] km1;
  logic [7:0] frameLen, lmfcLast, lmfcCnt_reg, rxPos_reg, prevLast_reg;
  logic [15:0] lmfcLen;
  rx_state_t state_reg, state_next;
  logic [2:0] kCount_reg;
  logic ilasSeen_reg, decOk, frameEnd, multiEnd, misplaced, cfgBad;
  symbol_t decSym, cand;
  logic [10:0] e0, e1;
  logic [7:0] recv;
  logic [22:0] descr;
  logic [14:0] dscr_reg;

  assign ctrl = {ctrlByte_reg[3], ctrlByte_reg[2], ctrlByte_reg[1],
    ctrlByte_reg[0]};
  assign rxRst = !resetn || !ctrl[`CTRL_ENABLE_BIT];
  assign scrEn = ctrl[`CTRL_SCR_BIT];
  assign mode = ctrl[`CTRL_MODE_LSB +: 2];
  assign km1 = ctrl[`CTRL_KM1_LSB +: 5];
  assign frameLen = octetsPerFrame(mode);
  assign lmfcLen = frameLen * ({3'h0, km1} + 8'h01);
  assign lmfcLast = 8'(lmfcLen - 16'h0001);
  assign frameEnd = (rxPos_reg & (frameLen - 8'h01)) ==
    (frameLen - 8'h01);
  assign multiEnd = rxPos_reg == lmfcLast;

  // Link requests alignment while not aligned
  assign link.syncN = state_reg == RX_ILAS || state_reg == RX_DATA;

  // Table search decode of the incoming character
  always_comb
  begin
    decOk = 1'b0;
    decSym = '0;
    cand = '0;
    e0 = '0;
    e1 = '0;
    for (int i = 0; i < 264; i++)
    begin
      cand = (i < 256) ? {1'b0, 8'(i)} : {1'b1, 3'(i - 256), `K28_LOW};
      e0 = encode8b10b(cand, 1'b0);
      e1 = encode8b10b(cand, 1'b1);
      if (e0[9:0] == link.txChar || e1[9:0] == link.txChar)
      begin
        decOk = 1'b1;
        decSym = cand;
      end
    end
  end

  assign misplaced = decSym.isK && !((decSym.octet == `OCT_K28_7 &&
    frameEnd) || (decSym.octet == `OCT_K28_3 && multiEnd));
  assign recv = decSym.isK ? (scrEn ? decSym.octet : prevLast_reg) :
    decSym.octet;
  assign descr = scrambleStep(recv, dscr_reg, 1'b1);
  assign cfgBad = state_reg == RX_ILAS && ilasSeen_reg &&
    mf_reg == `ILAS_CFG_MF && rxPos_reg >= `ILAS_CFG_FIRST &&
    rxPos_reg <= `ILAS_CFG_LAST &&
    decSym.octet != cfgOctet(rxPos_reg, mode, km1, scrEn);

  always_ff @(posedge clk)
  begin
    if (rxRst)
    begin
      sysrefD_reg <= 1'b0;
      lmfcCnt_reg <= 8'h00;
    end
    else if (ce)
    begin
      sysrefD_reg <= sysref;
      if ((sysref && !sysrefD_reg) || lmfcCnt_reg == lmfcLast)
        lmfcCnt_reg <= 8'h00;
      else
        lmfcCnt_reg <= lmfcCnt_reg + 8'h01;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      RX_CGS:
        if (kCount_reg == `CGS_K_LAST && decOk &&
          decSym == {1'b1, `OCT_K28_5})
          state_next = RX_WAIT;
      RX_WAIT:
        if (lmfcCnt_reg == lmfcLast)
          state_next = RX_ILAS;
      RX_ILAS:
        if (!decOk)
          state_next = RX_CGS;
        else if (ilasSeen_reg && multiEnd && mf_reg == `ILAS_LAST_MF)
          state_next = RX_DATA;
      RX_DATA:
        if (!decOk || misplaced)
          state_next = RX_CGS;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rxRst)
    begin
      state_reg <= RX_CGS;
      kCount_reg <= 3'h0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      if (state_reg == RX_CGS && decOk && decSym == {1'b1, `OCT_K28_5})
        kCount_reg <= kCount_reg + 3'h1;
      else
        kCount_reg <= 3'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rxRst || (ce && state_next == RX_CGS))
    begin
      ilasSeen_reg <= 1'b0;
      rxPos_reg <= 8'h00;
      mf_reg <= 2'h0;
    end
    else if (ce)
    begin
      if (state_reg == RX_ILAS && !ilasSeen_reg)
      begin
        if (decOk && decSym == {1'b1, `OCT_K28_0})
        begin
          ilasSeen_reg <= 1'b1;
          rxPos_reg <= 8'h01;
        end
      end
      else if (state_reg != RX_WAIT)
      begin
        rxPos_reg <= multiEnd ? 8'h00 : rxPos_reg + 8'h01;
        if (multiEnd)
          mf_reg <= mf_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rxRst)
    begin
      prevLast_reg <= 8'h00;
      dscr_reg <= `SCR_SEED;
      rxData <= 8'h00;
      rxValid <= 1'b0;
    end
    else if (ce)
    begin
      rxValid <= state_reg == RX_DATA && decOk && !misplaced;
      if (state_reg == RX_DATA)
      begin
        rxData <= scrEn ? descr[7:0] : recv;
        dscr_reg <= descr[22:8];
        if (frameEnd)
          prevLast_reg <= recv;
      end
    end
  end

  // Control register, one flop group per byte lane
  assign wrFire = awvalid && wvalid && !bvalid;
  assign awready = wrFire;
  assign wready = wrFire;
  assign arready = !rvalid;
  for (genvar b = 0; b < 4; b++)
  begin : ctrlLane
    always_ff @(posedge clk)
    begin
      if (!resetn)
        ctrlByte_reg[b] <= CtrlReset[8 * b +: 8];
      else if (ce && wrFire && awaddr == `REG_CTRL && wstrb[b])
        ctrlByte_reg[b] <= wdata[8 * b +: 8];
    end
  end

  // Sticky errors, set beats write-one-clear
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      alignErr_reg <= 1'b0;
      cfgErr_reg <= 1'b0;
    end
    else if (ce)
    begin
      alignErr_reg <= (state_reg == RX_DATA && (!decOk || misplaced)) ||
        (alignErr_reg && !(wrFire && awaddr == `REG_STATUS &&
        wstrb[0] && wdata[`STAT_ALIGN_BIT]));
      cfgErr_reg <= cfgBad || (cfgErr_reg && !(wrFire &&
        awaddr == `REG_STATUS && wstrb[0] && wdata[`STAT_CFG_BIT]));
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h00000000;
    end
    else if (ce)
    begin
      if (wrFire)
      begin
        bvalid <= 1'b1;
        bresp <= addrKnown(awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
      if (arvalid && !rvalid)
      begin
        rvalid <= 1'b1;
        rresp <= addrKnown(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (araddr)
          `REG_CTRL: rdata <= ctrl;
          `REG_STATUS: rdata <= {28'h0000000, cfgErr_reg, alignErr_reg,
            state_reg == RX_DATA, link.syncN};
          `REG_DATA: rdata <= {24'h000000, rxData};
          default: rdata <= 32'h00000000;
        endcase
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end
endmodule // jesd_link_rx

// file: hw/jesd_link_tx.sv
// Link transmitter end of a sampling converter: sample mapping,
// comma stream, lane alignment sequence, scrambling, alignment
// character substitution, 8b/10b coding and serializer control.
// Assumes syncN and sysref are synchronous to clk.
//
// Overview of operation
// - SYSREF rising edge restarts the multiframe counter
// - Receiver drives syncN low to request alignment
// - syncN low sends continuous K28.5 characters
// - Receiver locks after four consecutive K28.5
// - Receiver releases syncN at its multiframe edge
// - After syncN release wait for next multiframe edge
// - Alignment sequence lasts exactly four multiframes
// - Second alignment multiframe carries configuration octets
// - Alignment sequence is never scrambled
// - Scramble data only when scramble enable set
// - Receiver descrambler synchronizes itself
// - Octets become 10-bit characters with disparity
// - Unscrambled repeated frame end becomes K28.7
// - Repeat at multiframe end becomes K28.3
// - Scrambled frame end 0xFC becomes K28.7
// - Scrambled multiframe end 0x7C becomes K28.3
// - Receiver restores alignment characters, flags misplaced
// - Mode select and K shape the sample mapping
// - Pre-emphasis level drives serializer equalization
// - Host disables block before changing parameters
// - Disabled block held reset, serializer powered down
// - Without SYSREF multiframe counter runs freely
`timescale 1ns/1ns
`include "jesd_link_params.svh"
module jesd_link_tx (
  // Clock and control
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Link configuration, change only while disabled
  input wire logic linkBlockEnable,
  input wire logic scrambleEnable,
  input wire logic [1:0] linkModeSelect,
  input wire logic [4:0] framesPerMultiMinus1,
  input wire logic [3:0] serializerPreemphasisLevel,
  // Timing reference
  input wire logic sysref,
  // Sample stream
  input wire logic [7:0] sampleData,
  input wire logic sampleValid,
  output logic sampleReady,
  // Status
  output jesd_link_pkg::tx_state_t linkState,
  // Link
  jesd_link_if.tx link
);
  import jesd_link_pkg::*;

  logic linkRst;
  logic [7:0] frameLen;
  logic [15:0] lmfcLen;
  logic [7:0] lmfcLast;
  logic sysrefD_reg;
  logic [7:0] lmfcCnt_reg;
  logic frameEnd;
  logic multiEnd;
  tx_state_t state_reg;
  tx_state_t state_next;
  logic [1:0] ilasMf_reg;
  logic [7:0] rawOctet;
  logic [22:0] scrOut;
  logic [14:0] scr_reg;
  logic [7:0] prevLast_reg;
  logic prevValid_reg;
  symbol_t sym;
  logic [3:0] txEmph_reg;
  logic txPowered_reg;

  // Whole link held in reset while disabled
  assign linkRst = !resetn || !linkBlockEnable;

  // Frame and multiframe geometry
  assign frameLen = octetsPerFrame(linkModeSelect);
  assign lmfcLen = frameLen * ({3'h0, framesPerMultiMinus1} + 8'h01);
  assign lmfcLast = 8'(lmfcLen - 16'h0001);
  assign frameEnd = (lmfcCnt_reg & (frameLen - 8'h01)) ==
    (frameLen - 8'h01);
  assign multiEnd = lmfcCnt_reg == lmfcLast;

  // Multiframe counter, restarted by SYSREF, else free running
  always_ff @(posedge clk)
  begin
    if (linkRst)
    begin
      sysrefD_reg <= 1'b0;
      lmfcCnt_reg <= 8'h00;
    end
    else if (ce)
    begin
      sysrefD_reg <= sysref;
      if (sysref && !sysrefD_reg)
        lmfcCnt_reg <= 8'h00;
      else if (multiEnd)
        lmfcCnt_reg <= 8'h00;
      else
        lmfcCnt_reg <= lmfcCnt_reg + 8'h01;
    end
  end

  // Link sequence
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      TX_CGS:
        if (link.syncN)
          state_next = TX_WAIT;
      TX_WAIT:
        if (!link.syncN)
          state_next = TX_CGS;
        else if (multiEnd)
          state_next = TX_ILAS;
      TX_ILAS:
        if (!link.syncN)
          state_next = TX_CGS;
        else if (multiEnd && ilasMf_reg == `ILAS_LAST_MF)
          state_next = TX_DATA;
      TX_DATA:
        if (!link.syncN)
          state_next = TX_CGS;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (linkRst)
      state_reg <= TX_CGS;
    else if (ce)
      state_reg <= state_next;
  end

  // Alignment multiframe index
  always_ff @(posedge clk)
  begin
    if (linkRst)
      ilasMf_reg <= 2'h0;
    else if (ce)
    begin
      if (state_reg != TX_ILAS)
        ilasMf_reg <= 2'h0;
      else if (multiEnd)
        ilasMf_reg <= ilasMf_reg + 2'h1;
    end
  end

  // One sample per octet; idle octet when the source has none
  assign sampleReady = state_reg == TX_DATA;
  assign rawOctet = sampleValid ? sampleData : `IDLE_OCTET;
  assign scrOut = scrambleStep(rawOctet, scr_reg, 1'b0);

  // Symbol selection
  always_comb
  begin
    sym = {1'b1, `OCT_K28_5};
    unique case (state_reg)
      TX_CGS, TX_WAIT:
        sym = {1'b1, `OCT_K28_5};
      TX_ILAS:
        if (lmfcCnt_reg == 8'h00)
          sym = {1'b1, `OCT_K28_0};
        else if (multiEnd)
          sym = {1'b1, `OCT_K28_3};
        else if (ilasMf_reg == `ILAS_CFG_MF &&
          lmfcCnt_reg == `ILAS_Q_POS)
          sym = {1'b1, `OCT_K28_4};
        else if (ilasMf_reg == `ILAS_CFG_MF &&
          lmfcCnt_reg <= `ILAS_CFG_LAST)
          sym = {1'b0, cfgOctet(lmfcCnt_reg, linkModeSelect,
            framesPerMultiMinus1, scrambleEnable)};
        else
          sym = {1'b0, lmfcCnt_reg};
      TX_DATA:
        if (scrambleEnable)
        begin
          sym = {1'b0, scrOut[7:0]};
          if (multiEnd && scrOut[7:0] == `OCT_K28_3)
            sym = {1'b1, `OCT_K28_3};
          else if (frameEnd && scrOut[7:0] == `OCT_K28_7)
            sym = {1'b1, `OCT_K28_7};
        end
        else
        begin
          sym = {1'b0, rawOctet};
          if (frameEnd && prevValid_reg && rawOctet == prevLast_reg)
            sym = {1'b1, multiEnd ? `OCT_K28_3 : `OCT_K28_7};
        end
    endcase
  end

  // Scrambler runs only on data octets
  always_ff @(posedge clk)
  begin
    if (linkRst)
      scr_reg <= `SCR_SEED;
    else if (ce && state_reg == TX_DATA && scrambleEnable)
      scr_reg <= scrOut[22:8];
  end

  // Last octet of the previous data frame
  always_ff @(posedge clk)
  begin
    if (linkRst)
    begin
      prevLast_reg <= 8'h00;
      prevValid_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (state_reg != TX_DATA)
        prevValid_reg <= 1'b0;
      else if (frameEnd)
      begin
        prevLast_reg <= rawOctet;
        prevValid_reg <= 1'b1;
      end
    end
  end

  // Serializer drive; no drive and no emphasis while disabled
  always_ff @(posedge clk)
  begin
    if (linkRst)
    begin
      txEmph_reg <= 4'h0;
      txPowered_reg <= 1'b0;
    end
    else if (ce)
    begin
      txEmph_reg <= serializerPreemphasisLevel;
      txPowered_reg <= 1'b1;
    end
  end

  assign link.txEmph = txEmph_reg;
  assign link.txPowered = txPowered_reg;
  assign linkState = state_reg;

  // Encoder disparity also restarts with the link
  jesd_char_encoder charEnc (
    .clk(clk),
    .resetn(!linkRst),
    .ce(ce),
    .symIn(sym),
    .charOut(link.txChar)
  );
endmodule // jesd_link_tx

// file: test/jesd_link_properties.sv
// Checker for the serial link between transmitter and receiver.
// Assumes one clock domain and the interface signals as inputs.
`timescale 1ns/1ns
module jesd_link_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link signals
  input wire logic [9:0] txChar,
  input wire logic syncN,
  input wire logic [3:0] txEmph,
  input wire logic txPowered
);
  logic isK285, isK280, isK283, isK284, heavyReg;
  logic [3:0] ones;
  assign isK285 = txChar == 10'h0FA || txChar == 10'h305;
  assign isK280 = txChar == 10'h0F4 || txChar == 10'h30B;
  assign isK283 = txChar == 10'h0F3 || txChar == 10'h30C;
  assign isK284 = txChar == 10'h0F2 || txChar == 10'h30D;
  assign ones = 4'($countones(txChar));
  // Sign of the last unbalanced character
  always_ff @(posedge clk)
    heavyReg <= (!resetn || !txPowered) ? 1'h0 : (ones == 4'h6) ? 1'h1 :
      (ones == 4'h4) ? 1'h0 : heavyReg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  comma_stream_a: assert property
    ((!syncN)[*3] ##0 txPowered |-> isK285)
    else $error("comma stream missing while syncN low");
  disabled_quiet_a: assert property
    (!txPowered |-> txChar == 10'h000 && txEmph == 4'h0)
    else $error("disabled link not quiet");
  power_comma_a: assert property
    ($rose(txPowered) |-> txChar == 10'h0FA)
    else $error("first character after enable wrong");
  emph_hold_a: assert property
    (txPowered && $past(txPowered) |-> $stable(txEmph))
    else $error("emphasis changed while running");
  ilas_wait_a: assert property
    (isK280 && $past(isK285) |-> $past(syncN, 2))
    else $error("alignment started with syncN low");
  mf_start_a: assert property
    (isK280 |-> $past(isK285) || $past(isK283))
    else $error("multiframe start misplaced");
  cfg_mark_a: assert property
    (isK284 |-> $past(isK280))
    else $error("configuration marker misplaced");
  disp_heavy_a: assert property
    (ones == 4'h6 |-> !heavyReg)
    else $error("two positive characters in a row");
  disp_light_a: assert property
    (ones == 4'h4 |-> heavyReg)
    else $error("two negative characters in a row");
  char_weight_a: assert property
    (txPowered |-> ones >= 4'h4 && ones <= 4'h6)
    else $error("character weight out of range");
  cover property (isK284);
  cover property (txChar == 10'h0F8 || txChar == 10'h307);
  cover property ($rose(syncN));
endmodule // jesd_link_properties

// file: test/tb_top.sv
// Testbench: both link ends joined, receiver set over AXI4-Lite.
// Assumes the design package and header on the include path.
`timescale 1ns/1ns
`include "jesd_link_params.svh"
module tb_top;
  import jesd_link_pkg::*;
  logic clk = 1'h0, resetn = 1'h0, sysref = 1'h0;
  logic linkBlockEnable = 1'h0, scrambleEnable = 1'h0;
  logic [1:0] linkModeSelect = 2'h0;
  logic [4:0] framesPerMultiMinus1 = 5'h07;
  logic [3:0] serializerPreemphasisLevel = 4'h0, awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [7:0] sampleData = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, rxValid, sampleReady;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] rxData;
  tx_state_t linkState;
  int num_errors = 0, checked = 0;
  jesd_link_if link ();
  jesd_link_tx i_jesd_link_tx (.clk, .resetn, .ce(1'h1), .linkBlockEnable,
    .scrambleEnable, .linkModeSelect, .framesPerMultiMinus1,
    .serializerPreemphasisLevel, .sysref, .sampleData,
    .sampleValid(1'h1), .sampleReady, .linkState, .link(link));
  jesd_link_rx i_jesd_link_rx (.clk, .resetn, .ce(1'h1), .sysref, .awaddr,
    .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .rxData, .rxValid, .link(link));
  jesd_link_properties i_jesd_link_properties (.clk, .resetn,
    .txChar(link.txChar), .syncN(link.syncN), .txEmph(link.txEmph),
    .txPowered(link.txPowered));
  initial
  begin
    forever #25 clk = ~clk;
  end
  task automatic close_out;
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic hang;
    chk("timeout", 32'h0, 32'h1);
    close_out();
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
    output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 99; n++)
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
      r = bresp;
      if (bvalid)
        break;
    end
    bready <= 1'h0;
    if (n == 99)
      hang();
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 99; n++)
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'h0;
      d = rdata;
      r = rresp;
      if (rvalid)
        break;
    end
    rready <= 1'h0;
    if (n == 99)
      hang();
  endtask
  task automatic waitOn(input bit rx);
    int n;
    for (n = 0; n < 3000; n++)
    begin
      @(posedge clk);
      if (rx ? rxValid === 1'h1 : linkState === TX_DATA)
        break;
    end
    if (n == 3000)
      hang();
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axr(`REG_CTRL, d, r);
    chk("ctrl reset", `CTRL_RESET, d);
    axr(4'hC, d, r);
    chk("bad read resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    chk("bad read data", 32'h0, d);
    axw(4'hC, 32'h0000FFFF, r);
    chk("bad write resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    chk("tx powered", 32'h0, {31'h0, link.txPowered});
  endtask
  task automatic t_link(input logic [1:0] m, input logic s,
    input logic [1:0] rm);
    logic [31:0] d;
    logic [1:0] r;
    int n, k;
    linkBlockEnable <= 1'h0;
    axw(`REG_CTRL, 32'h0, r);
    axw(`REG_STATUS, 32'hC, r);
    chk("tx off", 32'h0, {31'h0, link.txPowered});
    scrambleEnable <= s;
    linkModeSelect <= m;
    serializerPreemphasisLevel <= {m, 2'h3};
    sampleData <= {6'h14, m};
    axw(`REG_CTRL, {23'h0, framesPerMultiMinus1, rm, s, 1'h1}, r);
    linkBlockEnable <= 1'h1;
    @(posedge clk);
    sysref <= 1'h1;
    @(posedge clk);
    sysref <= 1'h0;
    // Mismatched ends never reach data: wait a fixed span instead
    if (m == rm)
      waitOn(1'h0);
    else
      repeat (200) @(posedge clk);
    chk("emphasis", {28'h0, m, 2'h3}, {28'h0, link.txEmph});
    axr(`REG_STATUS, d, r);
    chk("cfg error", {31'h0, m != rm}, {31'h0, d[`STAT_CFG_BIT]});
    if (m == rm)
    begin
      waitOn(1'h1);
      chk("rx data", {24'h0, 6'h14, m}, {24'h0, rxData});
      chk("sample ready", 32'h1, {31'h0, sampleReady});
      axr(`REG_DATA, d, r);
      chk("data reg", {24'h0, 6'h14, m}, d);
      k = 0;
      for (n = 0; n < 64; n++)
      begin
        @(posedge clk);
        k += (link.txChar === 10'h0F8 || link.txChar === 10'h307);
      end
      if (!s)
        chk("frame marks", 32'h1, {31'h0, k != 0});
      axr(`REG_STATUS, d, r);
      chk("in data", 32'h2, d & 32'h6);
    end
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'h1;
    t_regs();
    for (int m = 0; m < 4; m++)
      t_link(2'(m), m[0], 2'(m));
    t_link(2'h1, 1'h0, 2'h0);
    close_out();
  end
endmodule // tb_top
